// ---- design/lpddr_fe_regs.svh ----
// Encodings, field positions and timing counts of the access front end
`ifndef LPDDR_FE_REGS_SVH
`define LPDDR_FE_REGS_SVH

// ----------------------------------------------------------------------
// Command opcodes (rising half of the command cycle, bits 5:3)
// ----------------------------------------------------------------------
`define OP_NOP 3'h0
`define OP_ACT 3'h1
`define OP_RD  3'h2
`define OP_WR  3'h3
`define OP_PRE 3'h4
`define OP_REF 3'h5
`define OP_SRE 3'h6
`define OP_DPD 3'h7

// ----------------------------------------------------------------------
// Falling half field positions
// ----------------------------------------------------------------------
`define CA_AP_BIT   5
`define CA_EXIT_BIT 0
`define CA_COL_HI   4

// ----------------------------------------------------------------------
// Latency floors and burst framing
// ----------------------------------------------------------------------
`define RL_MIN      4'h3
`define WL_MIN      4'h2
`define CYC_LAST    2'h3
`define DQS_TOGGLE  2'h1
`define DBI_LIMIT   4'h4

// ----------------------------------------------------------------------
// Self refresh pacing on the system clock
// ----------------------------------------------------------------------
`define SYS_CLK_KHZ      10000
`define SREF_INTERVAL_NS 3900
`define SREF_CYCLES      ((`SREF_INTERVAL_NS * `SYS_CLK_KHZ) / 1000000)

`endif

// ---- design/lpddr_fe_pkg.sv ----
// Types shared by the access front end
package lpddr_fe_pkg;

	// ------------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		P_ACTIVE = 2'b00,
		P_PDOWN  = 2'b01,
		P_SELF   = 2'b10,
		P_DEEP   = 2'b11
	} power_state_t;

	typedef enum logic [1:0]
	{
		B_IDLE = 2'b00,
		B_WAIT = 2'b01,
		B_XFER = 2'b10
	} burst_state_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed
	{
		logic [15:0] fall;
		logic [15:0] rise;
	} dq_pair_t;

	typedef struct packed
	{
		logic [1:0] fall;
		logic [1:0] rise;
	} mask_pair_t;

	typedef struct packed
	{
		logic       bl32;
		logic       interleave;
		logic [3:0] read_latency_setting;
		logic [3:0] write_latency_setting;
		logic       bus_inversion;
		logic       mask_en;
	} mode_cfg_t;

	typedef struct packed
	{
		logic [2:0] op;
		logic [2:0] bank;
		logic [5:0] addr;
	} ca_cmd_t;

endpackage : lpddr_fe_pkg

// ---- design/sync_level.sv ----
// Three-stage level synchroniser with agreement filter
module sync_level
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// Stage one is read only by stage two
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A bit moves only when stages two and three agree
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_sync <= '0;
		else
			o_sync <= (s2_reg & s3_reg) | (o_sync & (s2_reg | s3_reg));
	end

endmodule : sync_level

// ---- design/mem_array.sv ----
// Wide array with byte enables and registered read data
module mem_array
#(
	parameter int ADDR_W = 11,
	parameter int BYTES  = 16
)
(
	input  wire logic               i_clk,
	input  wire logic               i_we,
	input  wire logic [BYTES-1:0]   i_be,
	input  wire logic               i_re,
	input  wire logic [ADDR_W-1:0]  i_addr,
	input  wire logic [8*BYTES-1:0] i_wdata,
	output logic      [8*BYTES-1:0] o_rdata
);

	logic [8*BYTES-1:0] mem [0:(1<<ADDR_W)-1];

	// Masked bytes keep their old contents
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			for (int b = 0; b < BYTES; b++)
			begin
				if (i_be[b])
					mem[i_addr][8*b +: 8] <= i_wdata[8*b +: 8];
			end
		end
	end

	// Read port
	always_ff @(posedge i_clk)
	begin
		if (i_re)
			o_rdata <= mem[i_addr];
	end

endmodule : mem_array

// ---- design/lpddr4_access_front_end.sv ----
// Device-side command, bank, burst and power front end of a low power DDR channel
`include "lpddr_fe_regs.svh"

module lpddr4_access_front_end
	import lpddr_fe_pkg::*;
#(
	parameter int ROW_W = 6
)
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_resetn,
	input  wire logic       i_true_clock,
	input  wire logic       i_cke,
	input  wire logic       i_cs,
	input  wire logic [5:0] i_ca,
	input  wire mode_cfg_t  i_cfg,
	input  wire dq_pair_t   i_dq,
	output dq_pair_t        o_dq,
	output logic            o_dq_oe_n,
	input  wire logic [1:0] i_dqs,
	output logic      [1:0] o_dqs,
	output logic            o_dqs_oe_n,
	input  wire mask_pair_t i_mask_inversion_line,
	output mask_pair_t      o_mask_inversion_line,
	output logic            o_mask_inversion_oe_n,
	output power_state_t    o_power_state,
	output logic      [7:0] o_open_banks,
	output logic     [15:0] o_refresh_count,
	input  wire logic [7:0] i_partial_array_refresh,
	input  wire logic       i_temp_hot,
	output logic     [15:0] o_self_refresh_count,
	output logic            o_self_refresh_active
);

	localparam int ADDR_W = 3 + ROW_W + 2;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Word position of a step within the burst order
	function automatic logic [2:0] order_pos(input logic [2:0] start,
		input logic [2:0] step, input logic ilv);
		order_pos = ilv ? (start ^ step) : 3'(start + step);
	endfunction : order_pos

	// Inversion encode of one byte: {flag, data}
	function automatic logic [8:0] dbi_enc(input logic [7:0] b, input logic en);
		logic [3:0] ones;
		ones = 4'h0;
		for (int i = 0; i < 8; i++)
			ones = 4'(ones + {3'h0, b[i]});
		dbi_enc = (en && ones > `DBI_LIMIT) ? {1'b1, ~b} : {1'b0, b};
	endfunction : dbi_enc

	// ------------------------------------------------------------------
	// Command capture on the link clock
	// ------------------------------------------------------------------
	logic [5:0]   rise_reg;
	logic [5:0]   fall_reg;
	logic         cs_reg;
	logic         cke_reg;
	ca_cmd_t      cmd;
	logic         cmd_valid;
	logic         act_ok;
	power_state_t pstate_reg;
	power_state_t pstate_next;
	burst_state_t bstate_reg;

	// Rising half, chip select and clock enable
	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rise_reg <= 6'h00;
			cs_reg   <= 1'b0;
			cke_reg  <= 1'b0;
		end
		else
		begin
			rise_reg <= i_ca;
			cs_reg   <= i_cs;
			cke_reg  <= i_cke;
		end
	end

	// Falling half, i.e. the rising edge of the complement clock
	always_ff @(negedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			fall_reg <= 6'h00;
		else
			fall_reg <= i_ca;
	end

	// Both halves form one command; decoded at the next rising edge
	assign cmd       = ca_cmd_t'({rise_reg, fall_reg});
	assign cmd_valid = cs_reg && cke_reg && (cmd.op != `OP_NOP);
	assign act_ok    = cmd_valid && (pstate_reg == P_ACTIVE);

	// ------------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------------
	// No timer lives on this clock, so a stopped clock loses nothing
	always_comb
	begin
		pstate_next = pstate_reg;
		case (pstate_reg)
			P_ACTIVE:
			begin
				if (!cke_reg && bstate_reg == B_IDLE)
					pstate_next = P_PDOWN;
				else if (act_ok && bstate_reg == B_IDLE && !cmd.addr[`CA_EXIT_BIT])
				begin
					if (cmd.op == `OP_SRE)
						pstate_next = P_SELF;
					else if (cmd.op == `OP_DPD)
						pstate_next = P_DEEP;
				end
			end
			P_PDOWN:
			begin
				if (cke_reg)
					pstate_next = P_ACTIVE;
			end
			P_SELF:
			begin
				if (cmd_valid && cmd.op == `OP_SRE && cmd.addr[`CA_EXIT_BIT])
					pstate_next = P_ACTIVE;
			end
			P_DEEP:
			begin
				if (cmd_valid && cmd.op == `OP_DPD && cmd.addr[`CA_EXIT_BIT])
					pstate_next = P_ACTIVE;
			end
			default:
				pstate_next = P_ACTIVE;
		endcase
	end

	logic sref_reg;

	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pstate_reg <= P_ACTIVE;
			sref_reg   <= 1'b0;
		end
		else
		begin
			pstate_reg <= pstate_next;
			sref_reg   <= (pstate_next == P_SELF);
		end
	end

	// ------------------------------------------------------------------
	// Banks and burst engine
	// ------------------------------------------------------------------
	logic [7:0]       open_reg;
	logic [ROW_W-1:0] row_reg [0:7];
	logic [3:0]       wait_reg;
	logic [1:0]       cyc_reg;
	logic [1:0]       grp_reg;
	logic             wr_reg;
	logic             ap_reg;
	logic             bl32_reg;
	logic             ilv_reg;
	logic [2:0]       bank_reg;
	logic [ROW_W-1:0] brow_reg;
	logic [4:0]       col_reg;
	logic             start;
	logic             last_grp;
	logic             burst_end;
	logic [3:0]       rl;
	logic [3:0]       wl;

	assign start     = act_ok && bstate_reg == B_IDLE && open_reg[cmd.bank]
		&& (cmd.op == `OP_RD || cmd.op == `OP_WR);
	assign last_grp  = bl32_reg ? (grp_reg == 2'h3) : (grp_reg == 2'h1);
	assign burst_end = bstate_reg == B_XFER && cyc_reg == `CYC_LAST && last_grp;
	assign rl        = (i_cfg.read_latency_setting < `RL_MIN) ? `RL_MIN
		: i_cfg.read_latency_setting;
	assign wl        = (i_cfg.write_latency_setting < `WL_MIN) ? `WL_MIN
		: i_cfg.write_latency_setting;

	// Open-row state per bank
	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			open_reg <= 8'h00;
			for (int b = 0; b < 8; b++)
				row_reg[b] <= '0;
		end
		else if (pstate_next == P_DEEP)
			open_reg <= 8'h00;
		else
		begin
			if (act_ok && cmd.op == `OP_ACT)
			begin
				open_reg[cmd.bank] <= 1'b1;
				row_reg[cmd.bank]  <= ROW_W'(cmd.addr);
			end
			if (act_ok && cmd.op == `OP_PRE)
				open_reg[cmd.bank] <= 1'b0;
			if (burst_end && ap_reg)
				open_reg[bank_reg] <= 1'b0;
		end
	end

	// Latency wait, then four cycles per eight-word group
	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			bstate_reg <= B_IDLE;
			wait_reg   <= 4'h0;
			cyc_reg    <= 2'h0;
			grp_reg    <= 2'h0;
			wr_reg     <= 1'b0;
			ap_reg     <= 1'b0;
			bl32_reg   <= 1'b0;
			ilv_reg    <= 1'b0;
			bank_reg   <= 3'h0;
			brow_reg   <= '0;
			col_reg    <= 5'h00;
		end
		else
		begin
			case (bstate_reg)
				B_IDLE:
				begin
					if (start)
					begin
						bstate_reg <= B_WAIT;
						wr_reg     <= (cmd.op == `OP_WR);
						wait_reg   <= (cmd.op == `OP_WR) ? 4'(wl - 4'h1)
							: 4'(rl - 4'h2);
						ap_reg     <= cmd.addr[`CA_AP_BIT];
						bl32_reg   <= i_cfg.bl32;
						ilv_reg    <= i_cfg.interleave;
						bank_reg   <= cmd.bank;
						brow_reg   <= row_reg[cmd.bank];
						col_reg    <= cmd.addr[`CA_COL_HI:0];
						grp_reg    <= 2'h0;
						cyc_reg    <= 2'h0;
					end
				end
				B_WAIT:
				begin
					wait_reg <= 4'(wait_reg - 4'h1);
					if (wait_reg == 4'h1)
						bstate_reg <= B_XFER;
				end
				B_XFER:
				begin
					cyc_reg <= 2'(cyc_reg + 2'h1);
					if (cyc_reg == `CYC_LAST)
					begin
						grp_reg <= 2'(grp_reg + 2'h1);
						if (last_grp)
							bstate_reg <= B_IDLE;
					end
				end
				default:
					bstate_reg <= B_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Array access addressing
	// ------------------------------------------------------------------
	logic                mem_re;
	logic                mem_we;
	logic [1:0]          grp_sel;
	logic [2:0]          hi_calc;
	logic [1:0]          col_hi;
	logic [2:0]          w0;
	logic [2:0]          w1;
	logic [ADDR_W-1:0]   mem_addr;
	logic [127:0]        mem_rdata;
	logic [127:0]        acc;
	logic [15:0]         be;
	logic [127:0]        wr_acc_reg;
	logic [15:0]         wr_be_reg;

	// Reads fetch the next group one cycle ahead of its first beat
	assign mem_re  = !wr_reg && ((bstate_reg == B_WAIT && wait_reg == 4'h1)
		|| (bstate_reg == B_XFER && cyc_reg == `CYC_LAST && !last_grp));
	assign mem_we  = wr_reg && bstate_reg == B_XFER && cyc_reg == `CYC_LAST;
	assign grp_sel = (mem_re && bstate_reg == B_XFER) ? 2'(grp_reg + 2'h1) : grp_reg;
	assign hi_calc = order_pos({1'b0, col_reg[4:3]}, {1'b0, grp_sel}, ilv_reg);
	assign col_hi  = {bl32_reg ? hi_calc[1] : col_reg[4], hi_calc[0]};
	assign w0      = order_pos(col_reg[2:0], {cyc_reg, 1'b0}, ilv_reg);
	assign w1      = order_pos(col_reg[2:0], {cyc_reg, 1'b1}, ilv_reg);
	assign mem_addr = {bank_reg, brow_reg, col_hi};

	mem_array #(
		.ADDR_W (ADDR_W),
		.BYTES  (16)
	) i_mem_array (
		.i_clk   (i_true_clock),
		.i_we    (mem_we),
		.i_be    (be),
		.i_re    (mem_re),
		.i_addr  (mem_addr),
		.i_wdata (acc),
		.o_rdata (mem_rdata)
	);

	// ------------------------------------------------------------------
	// Write data path
	// ------------------------------------------------------------------
	// Mask takes precedence over inversion when both are enabled
	always_comb
	begin
		logic [15:0] wd0;
		logic [15:0] wd1;
		logic [1:0]  be0;
		logic [1:0]  be1;
		logic        strobe_ok;
		strobe_ok = (i_dqs == `DQS_TOGGLE);
		wd0 = i_dq.rise;
		wd1 = i_dq.fall;
		be0 = {2{strobe_ok}};
		be1 = {2{strobe_ok}};
		if (i_cfg.mask_en)
		begin
			be0 = be0 & ~i_mask_inversion_line.rise;
			be1 = be1 & ~i_mask_inversion_line.fall;
		end
		else if (i_cfg.bus_inversion)
		begin
			for (int k = 0; k < 2; k++)
			begin
				wd0[8*k +: 8] = wd0[8*k +: 8] ^ {8{i_mask_inversion_line.rise[k]}};
				wd1[8*k +: 8] = wd1[8*k +: 8] ^ {8{i_mask_inversion_line.fall[k]}};
			end
		end
		acc = wr_acc_reg;
		be  = (cyc_reg == 2'h0) ? 16'h0000 : wr_be_reg;
		acc[16*w0 +: 16] = wd0;
		acc[16*w1 +: 16] = wd1;
		be[2*w0 +: 2]    = be0;
		be[2*w1 +: 2]    = be1;
	end

	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wr_acc_reg <= '0;
			wr_be_reg  <= 16'h0000;
		end
		else if (wr_reg && bstate_reg == B_XFER)
		begin
			wr_acc_reg <= acc;
			wr_be_reg  <= be;
		end
	end

	// ------------------------------------------------------------------
	// Read data, strobe and inversion outputs
	// ------------------------------------------------------------------
	logic [8:0] enc [0:3];
	logic       rd_beat;

	assign rd_beat = !wr_reg && bstate_reg == B_XFER;

	// Four bytes per cycle, each judged on its own
	for (genvar g = 0; g < 4; g++)
	begin : g_dbi
		assign enc[g] = dbi_enc(mem_rdata[16*((g < 2) ? w0 : w1) + 8*(g % 2) +: 8],
			i_cfg.bus_inversion);
	end

	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_dq                  <= '0;
			o_dq_oe_n             <= 1'b1;
			o_dqs                 <= 2'h0;
			o_dqs_oe_n            <= 1'b1;
			o_mask_inversion_line <= '0;
			o_mask_inversion_oe_n <= 1'b1;
		end
		else
		begin
			o_dq.rise                  <= rd_beat ? {enc[1][7:0], enc[0][7:0]} : 16'h0000;
			o_dq.fall                  <= rd_beat ? {enc[3][7:0], enc[2][7:0]} : 16'h0000;
			o_mask_inversion_line.rise <= rd_beat ? {enc[1][8], enc[0][8]} : 2'h0;
			o_mask_inversion_line.fall <= rd_beat ? {enc[3][8], enc[2][8]} : 2'h0;
			o_dq_oe_n                  <= !rd_beat;
			o_mask_inversion_oe_n      <= !(rd_beat && i_cfg.bus_inversion);
			o_dqs                      <= rd_beat ? `DQS_TOGGLE : 2'h0;
			o_dqs_oe_n                 <= !rd_beat;
		end
	end

	// Status on the link clock
	always_ff @(posedge i_true_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_power_state   <= P_ACTIVE;
			o_open_banks    <= 8'h00;
			o_refresh_count <= 16'h0000;
		end
		else
		begin
			o_power_state <= pstate_next;
			o_open_banks  <= open_reg;
			if (act_ok && cmd.op == `OP_REF)
				o_refresh_count <= 16'(o_refresh_count + 16'h0001);
		end
	end

	// ------------------------------------------------------------------
	// Self refresh pacing on the system clock
	// ------------------------------------------------------------------
	// The link clock may be stopped in self refresh, so pacing lives here
	localparam logic [15:0] SREF_CYC = 16'(`SREF_CYCLES);

	logic [1:0]  sync_out;
	logic [15:0] timer_reg;
	logic [2:0]  sbank_reg;
	logic [15:0] limit;

	sync_level #(
		.WIDTH (2)
	) i_sync_level (
		.i_clk    (i_clk_sys),
		.i_resetn (i_resetn),
		.i_async  ({i_temp_hot, sref_reg}),
		.o_sync   (sync_out)
	);

	// Hot die refreshes twice as often
	assign limit = sync_out[1] ? (SREF_CYC >> 1) : SREF_CYC;

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			timer_reg             <= 16'h0000;
			sbank_reg             <= 3'h0;
			o_self_refresh_count  <= 16'h0000;
			o_self_refresh_active <= 1'b0;
		end
		else
		begin
			o_self_refresh_active <= sync_out[0];
			if (!sync_out[0])
				timer_reg <= 16'h0000;
			else if (timer_reg + 16'h0001 >= limit)
			begin
				timer_reg <= 16'h0000;
				sbank_reg <= 3'(sbank_reg + 3'h1);
				if (i_partial_array_refresh[sbank_reg])
					o_self_refresh_count <= 16'(o_self_refresh_count + 16'h0001);
			end
			else
				timer_reg <= 16'(timer_reg + 16'h0001);
		end
	end

endmodule : lpddr4_access_front_end

// ---- test/lpddr4_access_front_end_assertions.sv ----
// Port-level concurrent checks for the access front end
module fe_checker
	import lpddr_fe_pkg::*;
(
	input wire logic         i_clk_sys,
	input wire logic         i_resetn,
	input wire logic         i_true_clock,
	input wire logic         i_cke,
	input wire logic         i_cs,
	input wire logic [5:0]   i_ca,
	input wire mode_cfg_t    i_cfg,
	input wire dq_pair_t     o_dq,
	input wire logic         o_dq_oe_n,
	input wire logic [1:0]   o_dqs,
	input wire logic         o_dqs_oe_n,
	input wire mask_pair_t   o_mask_inversion_line,
	input wire logic         o_mask_inversion_oe_n,
	input wire power_state_t o_power_state,
	input wire logic [7:0]   o_open_banks,
	input wire logic [15:0]  o_refresh_count,
	input wire logic [15:0]  o_self_refresh_count,
	input wire logic         o_self_refresh_active
);
	// ----
	// Link domain
	// ----
	// Two clock domains here, so every property names its own clock
	// A command sampled at edge k is decoded at k+1 and counted at the sample of k+2
	a_ref_step: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		i_cs && i_cke && i_ca[5:3] == 3'h5 && o_power_state == P_ACTIVE
		|-> ##2 o_refresh_count == $past(o_refresh_count) + 16'h1) else $error("refresh missed");
	a_cs_ignore: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		!i_cs |-> ##2 $stable(o_refresh_count)) else $error("deselected command taken");
	a_strobe_form: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		o_dqs == {1'b0, !o_dqs_oe_n} && o_dq_oe_n == o_dqs_oe_n) else $error("strobe off data");
	a_burst16_len: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		$fell(o_dqs_oe_n) && !i_cfg.bl32 |-> (!o_dqs_oe_n) [*8] ##1 o_dqs_oe_n)
		else $error("short burst length");
	a_burst32_len: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		$fell(o_dqs_oe_n) && i_cfg.bl32 |-> (!o_dqs_oe_n) [*8] ##1 (!o_dqs_oe_n) [*8]
		##1 o_dqs_oe_n) else $error("long burst length");
	a_inv_ones: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		!o_mask_inversion_oe_n |-> i_cfg.bus_inversion && !o_dq_oe_n
		&& $countones(o_dq.rise[15:8]) <= (o_mask_inversion_line.rise[1] ? 3 : 4))
		else $error("inversion flag wrong");
	a_deep_closed: assert property (
		@(posedge i_true_clock) disable iff (!i_resetn)
		(o_power_state == P_DEEP) [*2] |-> o_open_banks == 8'h00) else $error("bank open in deep");

	// Self refresh pacing lives on the system clock
	a_sref_idle: assert property (
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!o_self_refresh_active |=> $stable(o_self_refresh_count)) else $error("refresh while awake");
endmodule : fe_checker

bind lpddr4_access_front_end fe_checker i_fe_checker (.*);

// ---- test/ctrl_model.sv ----
// Controller model on the far side of the link: clock, commands and data
module ctrl_model
	import lpddr_fe_pkg::*;
(
	output logic            o_clk,
	output logic            o_cke,
	output logic            o_cs,
	output logic [5:0]      o_ca,
	output dq_pair_t        o_dq,
	output logic [1:0]      o_dqs,
	output mask_pair_t      o_msk,
	input  wire dq_pair_t   i_dq,
	input  wire logic       i_oe_n,
	input  wire mask_pair_t i_inv
);
	timeunit 1ns;
	timeprecision 100ps;

	bit         run = 1'b1;
	logic       pre;
	logic       post;
	dq_pair_t   cap[16];
	mask_pair_t capf[16];

	// Quiet lines at start; data idles at all ones
	initial
	begin
		{o_clk, o_cke, o_cs, o_ca, o_dqs, o_msk} = '0;
		o_dq = '1;
	end

	// Clock may only halt low, so a stop never leaves half a cycle
	always
	begin
		#7.5;
		if (run || o_clk)
			o_clk = ~o_clk;
	end

	// One command cycle: op and bank, then address for the falling half
	task cmd(input logic cs, input logic [2:0] op, bank, input logic [5:0] adr);
		@(posedge o_clk) #2;
		{o_cke, o_cs, o_ca} = {1'b1, cs, op, bank};
		@(posedge o_clk) #2;
		{o_cs, o_ca} = {1'b0, adr};
		@(negedge o_clk) #2;
		o_ca = ~adr; // Stale address must not look valid
	endtask : cmd

	task cke_set(input logic v);
		@(posedge o_clk) #2;
		o_cke = v;
	endtask : cke_set

	// Burst placed by latency and sized to burst length
	task xfer(input logic wr, input logic [2:0] bank, input logic [5:0] adr,
		input int lat, input int ncyc, input logic [15:0] base, input mask_pair_t m);
		cmd(1'b1, wr ? 3'h3 : 3'h2, bank, adr);
		repeat (lat - 1) @(posedge o_clk);
		@(negedge o_clk) pre = i_oe_n;
		for (int c = 0; c < ncyc; c++)
		begin
			@(posedge o_clk) #2;
			if (wr)
				{o_dq, o_dqs, o_msk} = {base + 16'(2 * c + 1), base + 16'(2 * c), 2'b01, m};
			else
				@(negedge o_clk) {cap[c], capf[c]} = {i_dq, i_inv};
		end
		@(posedge o_clk) #2;
		{o_dq, o_dqs, o_msk} = {~o_dq, 2'b00, ~m};
		@(negedge o_clk) post = i_oe_n;
	endtask : xfer
endmodule : ctrl_model

// ---- test/test_lpddr4_access_front_end.sv ----
// Self-checking bench for the access front end
module test_lpddr4_access_front_end
	import lpddr_fe_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clk_sys  = 1'b0;
	logic         resetn   = 1'b0;
	logic         hot      = 1'b0;
	logic [7:0]   partial_array_refresh     = 8'h00;
	mode_cfg_t    cfg      = '0;
	logic         clk, cke, cs, dq_oe_n, dqs_oe_n, inv_oe_n, sr_act;
	logic [5:0]   ca;
	logic [1:0]   dqs_w, dqs_r;
	dq_pair_t     dq_w, dq_r;
	mask_pair_t   msk_w, msk_r;
	power_state_t pst;
	logic [7:0]   banks;
	logic [15:0]  refs, srefs, d;
	int           failures = 0;
	int           n_checks = 0;

	lpddr4_access_front_end i_lpddr4_access_front_end (
		.i_clk_sys(clk_sys), .i_resetn(resetn), .i_true_clock(clk), .i_cke(cke),
		.i_cs(cs), .i_ca(ca), .i_cfg(cfg), .i_dq(dq_w), .o_dq(dq_r), .o_dq_oe_n(dq_oe_n),
		.i_dqs(dqs_w), .o_dqs(dqs_r), .o_dqs_oe_n(dqs_oe_n), .i_mask_inversion_line(msk_w),
		.o_mask_inversion_line(msk_r), .o_mask_inversion_oe_n(inv_oe_n),
		.o_power_state(pst), .o_open_banks(banks), .o_refresh_count(refs),
		.i_partial_array_refresh(partial_array_refresh), .i_temp_hot(hot), .o_self_refresh_count(srefs),
		.o_self_refresh_active(sr_act));

	ctrl_model u_ctrl (.o_clk(clk), .o_cke(cke), .o_cs(cs), .o_ca(ca), .o_dq(dq_w),
		.o_dqs(dqs_w), .o_msk(msk_w), .i_dq(dq_r), .i_oe_n(dq_oe_n), .i_inv(msk_r));

	initial
		forever #50 clk_sys = ~clk_sys;

	task chk(input string what, input logic [15:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task settle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : settle

	// Array location of beat p from start s in the configured order
	function automatic logic [4:0] loc(input logic [4:0] s, p, input logic ilv, bl);
		logic [1:0] g;
		logic [2:0] w;
		w = ilv ? s[2:0] ^ p[2:0] : s[2:0] + p[2:0];
		g = ilv ? s[4:3] ^ p[4:3] : s[4:3] + p[4:3];
		g[1] = bl ? g[1] : s[4];
		return {g, w};
	endfunction : loc

	// Read bank 2; locations below lo hold the masked rewrite
	task rd(input logic [5:0] adr, input int lat, input logic [4:0] lo);
		logic [4:0] l;
		logic [1:0] f;
		u_ctrl.xfer(1'b0, 3'h2, adr, lat, cfg.bl32 ? 16 : 8, 16'h0, '0);
		chk("edge before", 16'h1, u_ctrl.pre);
		chk("edge after", 16'h1, u_ctrl.post);
		for (int p = 0; p < (cfg.bl32 ? 32 : 16); p++)
		begin
			l = loc(adr[4:0], 5'(p), cfg.interleave, cfg.bl32);
			d = p[0] ? u_ctrl.cap[p / 2].fall : u_ctrl.cap[p / 2].rise;
			f = p[0] ? u_ctrl.capf[p / 2].fall : u_ctrl.capf[p / 2].rise;
			if (cfg.bus_inversion)
				d = d ^ {{8{f[1]}}, {8{f[0]}}};
			chk("read word", (l < lo ? 16'h0300 : 16'hF800) + 16'(l), d);
		end
	endtask : rd

	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// Whole run is well under 60 us; the limit leaves ample margin
	initial
	begin
		#200000;
		failures++;
		test_done();
	end

	initial
	begin
		repeat (20) @(posedge clk_sys);
		#2 resetn = 1'b1;
		// Clock enable idles low, so the device starts in power down; wake it first
		u_ctrl.cke_set(1'b1);
		settle(3);
		chk("power", P_ACTIVE, pst);
		u_ctrl.cmd(1'b1, 3'h1, 3'h2, 6'h05);
		u_ctrl.cmd(1'b1, 3'h1, 3'h5, 6'h09);
		settle(4);
		chk("open banks", 16'h0024, banks);
		@(posedge clk) #2 cfg = {1'b1, 1'b0, 4'h5, 4'h3, 2'b01};
		u_ctrl.xfer(1'b1, 3'h2, 6'h00, 3, 16, 16'hF800, '0);
		@(posedge clk) #2 cfg = {1'b0, 1'b1, 4'h5, 4'h3, 2'b10};
		rd(6'h0D, 5, 5'd0);
		@(posedge clk) #2 cfg = {1'b0, 1'b0, 4'h5, 4'h2, 2'b01};
		u_ctrl.xfer(1'b1, 3'h2, 6'h00, 2, 8, 16'h0355, 4'b0101);
		@(posedge clk) #2 cfg = {1'b1, 1'b0, 4'h3, 4'h2, 2'b00};
		rd(6'h32, 3, 5'd16);
		settle(4);
		chk("open banks", 16'h0020, banks);
		u_ctrl.cmd(1'b1, 3'h5, 3'h0, 6'h00);
		u_ctrl.cmd(1'b0, 3'h5, 3'h0, 6'h00);
		u_ctrl.cmd(1'b1, 3'h5, 3'h0, 6'h00);
		settle(4);
		chk("refreshes", 16'h0002, refs);
		u_ctrl.cke_set(1'b0);
		settle(3);
		chk("power", P_PDOWN, pst);
		u_ctrl.cke_set(1'b1);
		settle(3);
		chk("power", P_ACTIVE, pst);
		u_ctrl.cmd(1'b1, 3'h6, 3'h0, 6'h00);
		settle(3);
		chk("power", P_SELF, pst);
		u_ctrl.run = 1'b0;
		repeat (100) @(posedge clk_sys);
		#2;
		chk("self active", 16'h1, sr_act);
		chk("no banks", 16'h0, srefs);
		{partial_array_refresh, hot} = {8'hFF, 1'b1};
		repeat (20) @(posedge clk_sys);
		#2 d = srefs;
		repeat (190) @(posedge clk_sys);
		#2 d = srefs - d;
		chk("hot rate", 16'h1, {15'h0, d >= 16'd9 && d <= 16'd11});
		u_ctrl.run = 1'b1;
		u_ctrl.cmd(1'b1, 3'h6, 3'h0, 6'h01);
		settle(3);
		chk("power", P_ACTIVE, pst);
		u_ctrl.cmd(1'b1, 3'h7, 3'h0, 6'h00);
		settle(4);
		chk("power", P_DEEP, pst);
		chk("open banks", 16'h0, banks);
		u_ctrl.cmd(1'b1, 3'h7, 3'h0, 6'h01);
		settle(3);
		chk("power", P_ACTIVE, pst);
		test_done();
	end
endmodule : test_lpddr4_access_front_end
